//--- pkg/dsd_pkg.sv
// Package for the diagnostic and socket DMA configuration bank.
// Assumes an APB slave with 32-bit data, byte offsets as printed.
package dsd_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] DSD_OFF_DIAG = 8'h93;
  localparam logic [7:0] DSD_OFF_DMA0 = 8'h94;
  localparam logic [7:0] DSD_OFF_DMA1 = 8'h98;
  // Word address of the diagnostic byte (lane 3 of word 90h)
  localparam logic [7:0] DSD_OFF_DIAG_WORD = 8'h90;
  localparam int DSD_DIAG_LANE = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DSD_DIAG_RST = 8'h61;
  localparam logic [31:0] DSD_DMA0_RST = 32'h00000000;
  localparam logic [31:0] DSD_DMA1_RST = 32'h00000000;

  // ==========================================================
  // Field positions in the diagnostic byte
  localparam int DSD_B_IDMASK = 7;
  localparam int DSD_B_OSCFS = 6;
  localparam int DSD_B_ROUTE = 5;
  localparam int DSD_B_RDIS = 4;
  localparam int DSD_B_REXT = 3;
  localparam int DSD_B_CBDS = 2;
  localparam int DSD_B_HDS = 1;
  localparam int DSD_B_STATUS_CHANGE_EN_A = 0;
  // Mask of bits that are global (function 0 copy only)
  localparam logic [7:0] DSD_GLOBAL_MASK = 8'h9e;

  // Socket DMA register 1 fields
  localparam int DSD_BASE_LSB = 4;
  localparam int DSD_BASE_MSB = 15;
  localparam int DSD_EXT_BIT = 3;

  // ==========================================================
  // Timing constants (cycles of the bridge clock)
  localparam logic [15:0] DSD_DISCARD_SHORT = 16'h0400;
  localparam logic [15:0] DSD_DISCARD_LONG = 16'h8000;
  localparam logic [6:0] DSD_RETRY_SHORT = 7'h10;
  localparam logic [6:0] DSD_RETRY_LONG = 7'h40;
  // Status-change routing needs legacy 805 bits 7-4 at this value
  localparam logic [3:0] DSD_LEG805_ROUTE_VAL = 4'h0;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    DSD_REQ_NONE = 2'h0,
    DSD_REQ_SPKR = 2'h1,
    DSD_REQ_IOIS16 = 2'h2,
    DSD_REQ_INPACK = 2'h3
  } dsd_req_pin_t;

  localparam logic [1:0] DSD_WIDTH_8 = 2'h0;
  localparam logic [1:0] DSD_WIDTH_16 = 2'h1;

  // Per-function register copy
  typedef struct packed {
    logic [7:0] diag;
    logic [1:0] req_pin;
    logic [11:0] base;
    logic [1:0] width;
    logic decode_en;
  } dsd_func_t;

  // Whole state of the block
  typedef struct packed {
    dsd_func_t f1;
    dsd_func_t f0;
    logic [31:0] prdata;
  } dsd_state_t;

  // Decoded configuration for one function
  typedef struct packed {
    logic id_mask_all_ones;
    logic osc_pm_failsafe;
    logic status_change_to_pci;
    logic status_change_en_a;
    logic delayed_txn_off;
    logic [6:0] retry_limit;
    logic [15:0] cardbus_discard_cycles;
    logic [15:0] host_discard_cycles;
    logic [1:0] dma_request_pin_sel;
    logic dma_16bit;
    logic window_hit;
  } dsd_cfg_t;

endpackage : dsd_pkg

//--- core/dsd_regs.sv
// Diagnostic and socket DMA configuration registers, two functions.
// Assumes APB master on pclk; pfunc selects bridge function 0 or 1.
`timescale 1ns/1ps
`default_nettype none

module dsd_regs
  import dsd_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pfunc,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Legacy socket register levels, per function
  input wire logic [1:0] leg803_bit4,
  input wire logic [7:0] leg805_hi,
  // PCI I/O address to check against each window
  input wire logic [31:0] io_addr,
  // Decoded configuration per function
  output dsd_pkg::dsd_cfg_t cfg0,
  output dsd_pkg::dsd_cfg_t cfg1
);
  import dsd_pkg::*;

  // ==========================================================
  // State
  dsd_state_t st_ff;
  dsd_state_t nxt_st;

  logic access;
  logic [7:0] word;
  logic [31:0] rd_val;
  logic [7:0] g_diag;

  assign access = psel && penable;
  assign word = {paddr[7:2], 2'b00};
  assign pready = 1'b1;
  assign pslverr = access && (word != DSD_OFF_DIAG_WORD) &&
                   (word != DSD_OFF_DMA0) && (word != DSD_OFF_DMA1);
  assign prdata = st_ff.prdata;

  // Function 1 sees global bits from function 0's copy
  function automatic logic [7:0] eff_diag(input logic [7:0] own,
                                          input logic [7:0] glob);
    eff_diag = (own & ~DSD_GLOBAL_MASK) | (glob & DSD_GLOBAL_MASK);
  endfunction : eff_diag

  // ==========================================================
  // Decode one function's configuration
  function automatic dsd_cfg_t decode(input dsd_func_t f,
                                      input logic [7:0] glob,
                                      input logic l803,
                                      input logic [3:0] l805,
                                      input logic [31:0] a);
    logic [7:0] d;
    d = eff_diag(f.diag, glob);
    decode.id_mask_all_ones = d[DSD_B_IDMASK];
    decode.osc_pm_failsafe = d[DSD_B_OSCFS];
    decode.status_change_to_pci = d[DSD_B_ROUTE] ?
      (l805 == DSD_LEG805_ROUTE_VAL) : l803;
    decode.status_change_en_a = d[DSD_B_STATUS_CHANGE_EN_A];
    decode.delayed_txn_off = d[DSD_B_RDIS];
    decode.retry_limit = d[DSD_B_REXT] ? DSD_RETRY_LONG :
                         DSD_RETRY_SHORT;
    decode.cardbus_discard_cycles = d[DSD_B_CBDS] ? DSD_DISCARD_SHORT :
                                    DSD_DISCARD_LONG;
    decode.host_discard_cycles = d[DSD_B_HDS] ? DSD_DISCARD_SHORT :
                                 DSD_DISCARD_LONG;
    decode.dma_request_pin_sel = f.req_pin;
    // Reserved width codes fall back to 8-bit; never wider than 16
    decode.dma_16bit = (f.width == DSD_WIDTH_16);
    decode.window_hit = f.decode_en && (a[31:16] == 16'h0000) &&
      (a[15:4] == f.base);
  endfunction : decode

  function automatic logic [31:0] read_word(input dsd_func_t f,
                                            input logic [7:0] glob,
                                            input logic [7:0] w);
    read_word = 32'h00000000;
    case (w)
      DSD_OFF_DIAG_WORD: read_word[31:24] = eff_diag(f.diag, glob);
      DSD_OFF_DMA0: read_word[1:0] = f.req_pin;
      // Bit 3 and bits 31-16 stay zero
      DSD_OFF_DMA1: read_word = {16'h0000, f.base, 1'b0, f.width,
                                 f.decode_en};
      default: read_word = 32'h00000000;
    endcase
  endfunction : read_word

  function automatic dsd_func_t write_fn(input dsd_func_t f,
                                         input logic [7:0] w,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    write_fn = f;
    case (w)
      DSD_OFF_DIAG_WORD: if (s[DSD_DIAG_LANE]) begin
        write_fn.diag = d[31:24];
      end
      DSD_OFF_DMA0: if (s[0]) begin
        write_fn.req_pin = d[1:0];
      end
      DSD_OFF_DMA1: begin
        if (s[0]) begin
          write_fn.width = d[2:1];
          write_fn.decode_en = d[0];
          write_fn.base[3:0] = d[7:4];
        end
        if (s[1]) begin
          write_fn.base[11:4] = d[15:8];
        end
      end
      default: write_fn = f;
    endcase
  endfunction : write_fn

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    g_diag = st_ff.f0.diag;
    rd_val = read_word(pfunc ? st_ff.f1 : st_ff.f0, g_diag, word);
    // Read data is latched at the end of the setup cycle so that it
    // already stands in the access phase, where the master samples it
    if (psel && !penable && !pwrite) begin
      nxt_st.prdata = rd_val;
    end
    if (access && pwrite) begin
      // Separate copies per function; an f1 write stores its global bits too, but only f0's are used
      if (pfunc) begin
        nxt_st.f1 = write_fn(st_ff.f1, word, pwdata, pstrb);
      end else begin
        nxt_st.f0 = write_fn(st_ff.f0, word, pwdata, pstrb);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.f0 <= '{diag: DSD_DIAG_RST, req_pin: 2'h0, base: 12'h000,
                    width: 2'h0, decode_en: 1'b0};
      st_ff.f1 <= '{diag: DSD_DIAG_RST, req_pin: 2'h0, base: 12'h000,
                    width: 2'h0, decode_en: 1'b0};
      st_ff.prdata <= 32'h00000000;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign cfg0 = decode(st_ff.f0, g_diag, leg803_bit4[0], leg805_hi[3:0],
                       io_addr);
  assign cfg1 = decode(st_ff.f1, g_diag, leg803_bit4[1], leg805_hi[7:4],
                       io_addr);

  // ==========================================================
  // Checks
  a_window_off_nohit: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.f0.decode_en |-> !cfg0.window_hit)
    else $error("window hit while decode disabled");
  a_window_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    io_addr[31:16] != 16'h0000 |-> !cfg0.window_hit && !cfg1.window_hit)
    else $error("window hit above 64K");
  a_dma1_read_clean: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && clk_en && word == DSD_OFF_DMA1 |=>
    prdata[31:16] == 16'h0000 && !prdata[DSD_EXT_BIT])
    else $error("dma1 reserved bits not zero");
  a_dma0_read_clean: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && clk_en && word == DSD_OFF_DMA0 |=>
    prdata[31:2] == 30'h0)
    else $error("dma0 reserved bits not zero");
  a_global_shared: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.id_mask_all_ones == cfg0.id_mask_all_ones &&
    cfg1.retry_limit == cfg0.retry_limit)
    else $error("global bit differs between functions");
  a_retry_limit_val: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.retry_limit == (st_ff.f0.diag[DSD_B_REXT] ? 7'h40 : 7'h10))
    else $error("retry limit wrong");
  a_discard_sel: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.f0.diag[DSD_B_HDS] |-> cfg0.host_discard_cycles == 16'h0400 &&
    cfg1.host_discard_cycles == 16'h0400)
    else $error("host discard select wrong");
  a_f1_write_isolate: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pfunc && clk_en |=> $stable(st_ff.f0))
    else $error("function 1 write changed function 0");
  a_width_cap: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.dma_16bit |-> st_ff.f0.width == DSD_WIDTH_16)
    else $error("wide transfer from reserved code");

  // ==========================================================
  // Bus sequences shared by the checks below
  sequence s_rd_setup;
    psel && !penable && !pwrite && clk_en;
  endsequence
  sequence s_wr_taken;
    access && pwrite && clk_en;
  endsequence
  sequence s_dma0_wr_f0;
    s_wr_taken and (!pfunc && word == DSD_OFF_DMA0 && pstrb[0]);
  endsequence
  sequence s_dma1_wr_f0;
    s_wr_taken and (!pfunc && word == DSD_OFF_DMA1 && pstrb[0]);
  endsequence
  sequence s_unmapped_wr;
    s_wr_taken and pslverr;
  endsequence

  // ==========================================================
  // Diagnostic decode checks
  a_idmask_f0: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.id_mask_all_ones == st_ff.f0.diag[DSD_B_IDMASK])
    else $error("identity mask decode wrong");
  a_idmask_f1: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.id_mask_all_ones == st_ff.f0.diag[DSD_B_IDMASK])
    else $error("function 1 identity mask not from function 0");
  a_osc_failsafe: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.osc_pm_failsafe == st_ff.f0.diag[DSD_B_OSCFS])
    else $error("oscillator fail-safe decode wrong");
  a_osc_f1_own: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.osc_pm_failsafe == st_ff.f1.diag[DSD_B_OSCFS])
    else $error("function 1 fail-safe not its own");
  a_route_legacy: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.f0.diag[DSD_B_ROUTE] |->
    cfg0.status_change_to_pci == leg803_bit4[0])
    else $error("status change routing by 803 wrong");
  a_route_805_f0: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.f0.diag[DSD_B_ROUTE] |->
    cfg0.status_change_to_pci == (leg805_hi[3:0] == 4'h0))
    else $error("status change routing by 805 wrong");
  a_route_805_f1: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.f1.diag[DSD_B_ROUTE] |->
    cfg1.status_change_to_pci == (leg805_hi[7:4] == 4'h0))
    else $error("function 1 routing by 805 wrong");
  a_status_change_en_a_en_f0: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.status_change_en_a == st_ff.f0.diag[DSD_B_STATUS_CHANGE_EN_A])
    else $error("status_change_en_a enable decode wrong");
  a_status_change_en_a_en_f1: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.status_change_en_a == st_ff.f1.diag[DSD_B_STATUS_CHANGE_EN_A])
    else $error("function 1 status_change_en_a enable wrong");
  a_retry_off: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.delayed_txn_off == st_ff.f0.diag[DSD_B_RDIS] &&
    cfg1.delayed_txn_off == st_ff.f0.diag[DSD_B_RDIS])
    else $error("delayed transaction disable wrong");
  a_retry_short: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.f0.diag[DSD_B_REXT] |-> cfg1.retry_limit == 7'h10)
    else $error("short retry limit wrong");
  a_cb_discard: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.cardbus_discard_cycles ==
    (st_ff.f0.diag[DSD_B_CBDS] ? 16'h0400 : 16'h8000))
    else $error("cardbus discard select wrong");
  a_cb_discard_f1: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.cardbus_discard_cycles ==
    (st_ff.f0.diag[DSD_B_CBDS] ? 16'h0400 : 16'h8000))
    else $error("function 1 cardbus discard wrong");
  a_host_long: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.f0.diag[DSD_B_HDS] |-> cfg0.host_discard_cycles == 16'h8000 &&
    cfg1.host_discard_cycles == 16'h8000)
    else $error("long host discard wrong");

  // ==========================================================
  // Socket DMA decode checks
  a_reqpin_f0: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.dma_request_pin_sel == st_ff.f0.req_pin)
    else $error("request pin decode wrong");
  a_reqpin_f1: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.dma_request_pin_sel == st_ff.f1.req_pin)
    else $error("function 1 request pin not its own");
  a_window_match: assert property (@(posedge pclk) disable iff (!presetn)
    cfg0.window_hit |-> io_addr[15:4] == st_ff.f0.base)
    else $error("window hit at wrong base");
  a_window_hit_f1: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.f1.decode_en && io_addr[31:16] == 16'h0000 &&
    io_addr[15:4] == st_ff.f1.base |-> cfg1.window_hit)
    else $error("function 1 window missed");
  a_window_off_f1: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.f1.decode_en |-> !cfg1.window_hit)
    else $error("function 1 hit while decode disabled");
  a_width_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.f0.width[1] |-> !cfg0.dma_16bit)
    else $error("reserved width decoded as 16-bit");
  a_width_16_f1: assert property (@(posedge pclk) disable iff (!presetn)
    cfg1.dma_16bit == (st_ff.f1.width == DSD_WIDTH_16))
    else $error("function 1 width decode wrong");

  // ==========================================================
  // Register access checks
  a_f0_write_isolate: assert property (@(posedge pclk)
    disable iff (!presetn)
    access && pwrite && !pfunc && clk_en |=> $stable(st_ff.f1))
    else $error("function 0 write changed function 1");
  a_unmapped_ignored: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_unmapped_wr |=> $stable(st_ff.f0) && $stable(st_ff.f1))
    else $error("unmapped write changed a register");
  a_dma0_write_land: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_dma0_wr_f0 |=> st_ff.f0.req_pin == $past(pwdata[1:0]))
    else $error("request pin write lost");
  a_dma1_write_land: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_dma1_wr_f0 |=> st_ff.f0.width == $past(pwdata[2:1]))
    else $error("width write lost");
  a_read_f1_own: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_setup and (pfunc && word == DSD_OFF_DMA0) |=>
    prdata == {30'h0, $past(st_ff.f1.req_pin)})
    else $error("function 1 read shows wrong copy");
  a_diag_read_f1: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_setup and (pfunc && word == DSD_OFF_DIAG_WORD) |=>
    (prdata[31:24] & DSD_GLOBAL_MASK) ==
    ($past(st_ff.f0.diag) & DSD_GLOBAL_MASK))
    else $error("function 1 global bits not from function 0");
  a_read_stands: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_setup |=> prdata == $past(rd_val))
    else $error("read data not latched in setup");

endmodule : dsd_regs

`default_nettype wire

//--- verification/dsd_legacy_model.sv
// Far-side model: legacy socket register levels seen by the bank.
// Assumes the bench loads new levels with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module dsd_legacy_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load request from the bench
  input wire logic ld,
  input wire logic [9:0] lvl,
  // Levels to the bank
  output logic [1:0] leg803_bit4,
  output logic [7:0] leg805_hi
);
  logic [9:0] leg_ff;
  // Legacy 805 high nibbles rest at all ones, never routing by default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leg_ff <= 10'h0ff;
    end else if (ld) begin
      leg_ff <= lvl;
    end
  end
  assign leg803_bit4 = leg_ff[9:8];
  assign leg805_hi = leg_ff[7:0];
endmodule : dsd_legacy_model
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the diagnostic and socket DMA bank.
// Assumes an APB slave whose read data stands in the access phase.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dsd_pkg::*;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic pfunc = 0, pready, pslverr, ld = 0, err;
  logic [7:0] paddr = 0, l805;
  logic [3:0] pstrb = 0;
  logic [1:0] l803;
  logic [9:0] lvl = 0;
  logic [31:0] pwdata = 0, prdata, rd, io_addr = 0;
  dsd_cfg_t cfg0, cfg1;
  int n_errors = 0, cmp_count = 0;
  always #12.5 pclk = ~pclk;
  dsd_legacy_model dsd_legacy_model_inst (.pclk(pclk), .presetn(presetn),
    .ld(ld), .lvl(lvl), .leg803_bit4(l803), .leg805_hi(l805));
  dsd_regs dsd_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pfunc(pfunc), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .leg803_bit4(l803),
    .leg805_hi(l805), .io_addr(io_addr), .cfg0(cfg0), .cfg1(cfg1));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; returns just after one
  task automatic apb(input logic w, input logic f, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    pfunc <= f;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps the next call from re-raising psel at once
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic f, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, f, a, 32'h0, 4'h0);
    chk(rd, e);
  endtask : rdc
  task automatic setlvl(input logic [9:0] v);
    lvl <= v;
    ld <= 1'b1;
    @(posedge pclk);
    ld <= 1'b0;
    @(posedge pclk);
  endtask : setlvl
  task automatic hit(input logic [31:0] a, input logic e);
    io_addr <= a;
    @(posedge pclk);
    chk(32'(cfg0.window_hit), 32'(e));
  endtask : hit
  task summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    #200us;
    n_errors++;
    summarize;
  end
  initial begin
    // A real falling edge, so the asynchronous reset surely fires
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int f = 0; f < 2; f++) begin
      rdc(f[0], 8'h90, 32'h61000000);
      rdc(f[0], 8'h94, 32'h0);
      rdc(f[0], 8'h98, 32'h0);
    end
    chk(32'(cfg0.status_change_en_a), 32'h1);
    chk(32'(cfg0.retry_limit), 32'd16);
    chk(32'(cfg0.cardbus_discard_cycles), 32'd32768);
    chk(32'(cfg0.host_discard_cycles), 32'd32768);
    setlvl(10'h0f0);
    chk(32'(cfg0.status_change_to_pci), 32'h1);
    chk(32'(cfg1.status_change_to_pci), 32'h0);
    apb(1'b1, 1'b0, 8'h98, 32'hffffffff, 4'hf);
    rdc(1'b0, 8'h98, 32'h0000fff7);
    rdc(1'b1, 8'h98, 32'h0);
    apb(1'b1, 1'b0, 8'h94, 32'hffffffff, 4'hf);
    rdc(1'b0, 8'h94, 32'h3);
    hit(32'h0000fff0, 1'b1);
    hit(32'h0001fff0, 1'b0);
    apb(1'b1, 1'b0, 8'h98, 32'h00001231, 4'h3);
    hit(32'h0000123f, 1'b1);
    hit(32'h00001240, 1'b0);
    apb(1'b1, 1'b0, 8'h98, 32'h00001230, 4'h3);
    hit(32'h00001230, 1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 1'b0, 8'h98, 32'(k) << 1, 4'h1);
      chk(32'(cfg0.dma_16bit), 32'(k == 1));
      apb(1'b1, 1'b0, 8'h94, 32'(k), 4'h1);
      chk(32'(cfg0.dma_request_pin_sel), 32'(k));
    end
    // Zeros only, as software is expected to write here
    apb(1'b1, 1'b0, 8'h90, 32'h0, 4'h8);
    chk(32'(cfg0.status_change_en_a), 32'h0);
    setlvl(10'h1ff);
    chk(32'(cfg0.status_change_to_pci), 32'h1);
    setlvl(10'h2f0);
    chk(32'(cfg0.status_change_to_pci), 32'h0);
    apb(1'b1, 1'b0, 8'h90, 32'hff000000, 4'h8);
    chk(32'(cfg0.id_mask_all_ones), 32'h1);
    chk(32'(cfg0.osc_pm_failsafe), 32'h1);
    chk(32'(cfg0.delayed_txn_off), 32'h1);
    chk(32'(cfg0.retry_limit), 32'd64);
    chk(32'(cfg0.cardbus_discard_cycles), 32'd1024);
    chk(32'(cfg0.host_discard_cycles), 32'd1024);
    chk(32'(cfg1.id_mask_all_ones), 32'h1);
    apb(1'b1, 1'b1, 8'h90, 32'h0, 4'h8);
    rdc(1'b1, 8'h90, 32'h9e000000);
    rdc(1'b0, 8'h90, 32'hff000000);
    apb(1'b1, 1'b0, 8'ha0, 32'h1, 4'hf);
    chk(32'(err), 32'h1);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
